/* File: rtl/wdt_map.svh */
// watchdog core constants: register offsets, field positions, reload key, timing counts
// assumes an Avalon-MM slave with 32-bit data and word-aligned byte addresses
// Operation
// - 18-bit up counter runs while enabled
// - time-out at 2^4 .. 2^18 watchdog clocks
// - reset delay of 1026, 130, 18 or 3 clocks
// - system held in reset about 63 clocks
// - boot config field forces watchdog on
// - wake-up only on low-speed clock sources
// - reset on unserviced time-out, wake from sleep
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define WDT_OFS_CTRL        4'h0
`define WDT_OFS_RELOAD      4'h4
`define WDT_OFS_STATUS      4'h8
`define WDT_OFS_INT_EN      4'hC

`define WDT_CTRL_EN_BIT     0
`define WDT_CTRL_WAKE_BIT   1
`define WDT_CTRL_RSTEN_BIT  2
`define WDT_CTRL_TOSEL_LSB  4
`define WDT_CTRL_DLYSEL_LSB 8
`define WDT_CTRL_SRC_LSB    12

`define WDT_RELOAD_KEY      32'h00005AA5

`define WDT_ST_TOUT_BIT     0
`define WDT_ST_RST_BIT      1
`define WDT_ST_WAKE_BIT     2

`define WDT_TOSEL_MAX       4'hE
`define WDT_TOUT_EXP_BASE   5'h04
`define WDT_HOLD_CLKS       7'h3F
`define WDT_DLY_0           11'h402
`define WDT_DLY_1           11'h082
`define WDT_DLY_2           11'h012
`define WDT_DLY_3           11'h003

`define WDT_SRC_LOWINT_CODE 2'h1
`define WDT_SRC_LOWXTAL_CODE 2'h2
`define WDT_FORCE_ON_CODE   3'h0

`endif

/* File: rtl/wdt_pkg.sv */
// watchdog core types
// assumes the map header is included by the design that uses these types
package wdt_pkg;
    typedef enum logic [2:0] {
        WDT_ST_COUNT = 3'h1,
        WDT_ST_DELAY = 3'h2,
        WDT_ST_HOLD  = 3'h4
    } wdt_state_t;

    typedef enum logic [1:0] {
        WATCHDOG_CLOCK_IN_HCLK = 2'h0,
        WATCHDOG_CLOCK_IN_LOWINT  = 2'h1,
        WATCHDOG_CLOCK_IN_LOWXTAL = 2'h2,
        WATCHDOG_CLOCK_IN_OTHR = 2'h3
    } wdt_src_t;
endpackage

/* File: rtl/wdt_core.sv */
// watchdog core with Avalon-MM register slave and sticky event interrupts
// assumes watchdog_clock_in is synchronous to core_clk_i; one core cycle per watchdog edge is sampled
`include "wdt_map.svh"

module wdt_core (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // watchdog clock, sampled as a level
    input  wire logic        watchdog_clock_in_i,
    // boot configuration and clock source
    input  wire logic [2:0]  forced_enable_cfg_i,
    input  wire logic [1:0]  clk_src_sel_i,
    input  wire logic        sys_sleep_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // system outputs
    output logic             sys_reset_o,
    output logic             wake_o,
    output logic             irq_o
);
    wdt_pkg::wdt_state_t state_r;
    wdt_pkg::wdt_state_t state_nxt;
    logic [17:0]         cnt_r;
    logic [10:0]         dly_r;
    logic [6:0]          hold_r;
    logic                wck_d_r;
    logic                en_r;
    logic                wake_en_r;
    logic                rst_en_r;
    logic [3:0]          tosel_r;
    logic [1:0]          dlysel_r;
    logic [2:0]          status_r;
    logic [2:0]          int_en_r;
    logic                boot_done_r;
    logic                ack_r;
    logic [31:0]         rdata_r;

    // decode
    wire        tick      = watchdog_clock_in_i & ~wck_d_r;
    wire        wr_ok     = avs_write_i & ack_r;  // lands where waitrequest is low
    wire        rd_ok     = avs_read_i & ~ack_r;
    wire        wr_ctrl   = wr_ok & (avs_address_i == `WDT_OFS_CTRL) & avs_byteenable_i[0];
    wire        wr_ctrl1  = wr_ok & (avs_address_i == `WDT_OFS_CTRL) & avs_byteenable_i[1];
    wire        wr_reload = wr_ok & (avs_address_i == `WDT_OFS_RELOAD) & (avs_writedata_i == `WDT_RELOAD_KEY);
    wire        wr_clr    = wr_ok & (avs_address_i == `WDT_OFS_STATUS) & avs_byteenable_i[0];
    wire        wr_inten  = wr_ok & (avs_address_i == `WDT_OFS_INT_EN) & avs_byteenable_i[0];
    wire [3:0]  tosel_eff = (tosel_r > `WDT_TOSEL_MAX) ? `WDT_TOSEL_MAX : tosel_r;
    wire [4:0]  tout_bit  = `WDT_TOUT_EXP_BASE + {1'b0, tosel_eff};
    wire [18:0] cnt_inc   = {1'b0, cnt_r} + 19'h00001;
    wire        tout_hit  = cnt_inc[tout_bit];
    wire        low_src   = (clk_src_sel_i == wdt_pkg::WATCHDOG_CLOCK_IN_LOWINT) |
                            (clk_src_sel_i == wdt_pkg::WATCHDOG_CLOCK_IN_LOWXTAL);
    wire [10:0] dly_len   = (dlysel_r == 2'h0) ? `WDT_DLY_0 :
                            (dlysel_r == 2'h1) ? `WDT_DLY_1 :
                            (dlysel_r == 2'h2) ? `WDT_DLY_2 : `WDT_DLY_3;
    wire        in_count  = (state_r == wdt_pkg::WDT_ST_COUNT);
    wire        in_delay  = (state_r == wdt_pkg::WDT_ST_DELAY);
    wire        in_hold   = (state_r == wdt_pkg::WDT_ST_HOLD);
    wire        force_on  = (forced_enable_cfg_i == `WDT_FORCE_ON_CODE);
    wire        tout_ev   = en_r & tick & in_count & tout_hit & ~wr_reload;
    wire        dly_done  = tick & in_delay & (dly_r == 11'h001) & ~wr_reload;
    wire        hold_done = tick & in_hold & (hold_r == 7'h01);
    wire        wake_ev   = tout_ev & wake_en_r & sys_sleep_i & low_src;
    wire [2:0]  ev_set    = {wake_ev, dly_done, tout_ev};
    wire [2:0]  clr_bit   = wr_clr ? avs_writedata_i[2:0] : 3'h0;
    wire [31:0] ctrl_rd   = {16'h0000, 2'h0, clk_src_sel_i, 2'h0, dlysel_r, tosel_r, 1'b0,
                             rst_en_r, wake_en_r, en_r};
    wire [31:0] rd_mux    = (avs_address_i == `WDT_OFS_CTRL)   ? ctrl_rd :
                            (avs_address_i == `WDT_OFS_RELOAD) ? {14'h0000, cnt_r} :
                            (avs_address_i == `WDT_OFS_STATUS) ? {29'h00000000, status_r} :
                            (avs_address_i == `WDT_OFS_INT_EN) ? {29'h00000000, int_en_r} : 32'h00000000;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
    assign avs_readdata_o    = rdata_r;
    assign irq_o             = |(status_r & int_en_r);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            wdt_pkg::WDT_ST_COUNT: begin
                if (tout_ev & rst_en_r)
                    state_nxt = wdt_pkg::WDT_ST_DELAY;
            end
            wdt_pkg::WDT_ST_DELAY: begin
                if (wr_reload)
                    state_nxt = wdt_pkg::WDT_ST_COUNT;
                else if (dly_done)
                    state_nxt = wdt_pkg::WDT_ST_HOLD;
            end
            wdt_pkg::WDT_ST_HOLD: begin
                if (hold_done)
                    state_nxt = wdt_pkg::WDT_ST_COUNT;
            end
            default: state_nxt = wdt_pkg::WDT_ST_COUNT;
        endcase
    end

    // bus handshake: one wait cycle, answer on the next edge
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
            if (rd_ok)
                rdata_r <= rd_mux;
        end
    end

    // enable; boot strap caught at the first edge after reset release
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_done_r <= 1'b0;
            en_r        <= 1'b0;
        end else begin
            boot_done_r <= 1'b1;
            if (!boot_done_r && force_on) begin
                en_r <= 1'b1;
            end else if (wr_ctrl) begin
                en_r <= avs_writedata_i[`WDT_CTRL_EN_BIT];
            end
        end
    end

    // control fields and interrupt enables
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_en_r <= 1'b0;
            rst_en_r  <= 1'b1;
            tosel_r   <= 4'h0;
            dlysel_r  <= 2'h0;
            int_en_r  <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                wake_en_r <= avs_writedata_i[`WDT_CTRL_WAKE_BIT];
                rst_en_r  <= avs_writedata_i[`WDT_CTRL_RSTEN_BIT];
                tosel_r   <= avs_writedata_i[`WDT_CTRL_TOSEL_LSB +: 4];
            end
            if (wr_ctrl1) begin
                dlysel_r <= avs_writedata_i[`WDT_CTRL_DLYSEL_LSB +: 2];
            end
            if (wr_inten) begin
                int_en_r <= avs_writedata_i[2:0];
            end
        end
    end

    // tick edge detect and state register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= wdt_pkg::WDT_ST_COUNT;
            wck_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wck_d_r <= watchdog_clock_in_i;
        end
    end

    // tick counter, counting only in the count state, cleared by reload, disable or time-out
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 18'h00000;
        end else if (wr_reload || !en_r || tout_ev) begin
            cnt_r <= 18'h00000;
        end else if (tick && in_count) begin
            cnt_r <= cnt_inc[17:0];
        end
    end

    // reset delay down-counter
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dly_r <= 11'h000;
        end else if (tout_ev) begin
            dly_r <= dly_len;
        end else if (tick && in_delay) begin
            dly_r <= dly_r - 11'h001;
        end
    end

    // reset hold down-counter
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= 7'h00;
        end else if (dly_done) begin
            hold_r <= `WDT_HOLD_CLKS;
        end else if (tick && in_hold) begin
            hold_r <= hold_r - 7'h01;
        end
    end

    // sticky status, one flop per event; set wins over clear
    generate
        for (genvar i = 0; i < 3; i++) begin : g_status
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status_r[i] <= 1'b0;
                end else if (ev_set[i]) begin
                    status_r[i] <= 1'b1;
                end else if (clr_bit[i]) begin
                    status_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // registered system outputs
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_reset_o <= 1'b0;
            wake_o      <= 1'b0;
        end else begin
            sys_reset_o <= (state_nxt == wdt_pkg::WDT_ST_HOLD);
            wake_o      <= wake_ev;
        end
    end
endmodule

/* File: test/wdt_checker.sv */
// watchdog core checker: port-level timing properties
// assumes a bind onto wdt_core; one clock domain
module wdt_checker (
    // clock, reset, levels
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic [1:0]  clk_src_sel_i,
    input wire logic        sys_sleep_i,
    // bus and outputs
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        sys_reset_o,
    input wire logic        wake_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire req_w = avs_read_i | avs_write_i;
    chk_wait_first: assert property ($rose(req_w) |-> avs_waitrequest_o)
        else $error("no wait cycle");
    chk_wait_once: assert property (req_w && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait too long");
    chk_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
        else $error("read data moved");
    chk_hold_min: assert property ($rose(sys_reset_o) |-> sys_reset_o[*8])
        else $error("reset hold too short");
    chk_hold_fall: assert property ($fell(sys_reset_o) |-> $past(sys_reset_o, 8))
        else $error("reset pulse too short");
    chk_delay_gap: assert property ($rose(sys_reset_o) |-> !$past(sys_reset_o, 6))
        else $error("reset without delay");
    chk_wake_src: assert property (wake_o |-> $past(clk_src_sel_i) inside {2'h1, 2'h2} && $past(sys_sleep_i))
        else $error("wake from wrong source");
    chk_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake not a pulse");
    cover property ($rose(sys_reset_o));
    cover property (wake_o);
    cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind wdt_core wdt_checker u_chk (.core_clk_i, .rst_n_i, .clk_src_sel_i, .sys_sleep_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .sys_reset_o, .wake_o);

/* File: test/tb_top.sv */
// watchdog core testbench: bus and tick drivers, integer reference
// assumes wdt_core and its checker are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i = 0;
    logic        rst_n_i = 0;
    logic        wd_clk = 0;
    logic        sleep = 1;
    logic [2:0]  cfg = 3'h5;
    logic [1:0]  src = 2'h0;
    logic [3:0]  addr = 4'h0;
    logic        rd = 0;
    logic        wr = 0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic        wreq, sys_rst, wake, irq;
    int          err_count = 0;
    int          total_checks = 0;
    int          wakes = 0;
    int          dly[4] = '{1026, 130, 18, 3};
    int          w, d, k;
    always #2.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (wake === 1'b1) wakes++;
    wdt_core dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .watchdog_clock_in_i(wd_clk),
        .forced_enable_cfg_i(cfg), .clk_src_sel_i(src), .sys_sleep_i(sleep), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .sys_reset_o(sys_rst), .wake_o(wake), .irq_o(irq));
    task finish_test;
        $display("errors %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input logic wi, input logic [3:0] a, input logic [31:0] dv);
        int n;
        logic ws;
        n = 0;
        addr <= a;
        wdata <= dv;
        rd <= !wi;
        wr <= wi;
        do begin
            @(negedge core_clk_i);
            ws = wreq;
            q = rdata;
            n++;
            @(posedge core_clk_i);
        end while (ws !== 1'b0 && n < 50);
        if (ws !== 1'b0) begin
            err_count++;
            finish_test;
        end
        rd <= 0;
        wr <= 0;
        @(posedge core_clk_i);
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        cmp(q, e);
    endtask
    task tick(input int n);
        repeat (n) begin
            wd_clk <= 1;
            repeat (2) @(posedge core_clk_i);
            wd_clk <= 0;
            repeat (2) @(posedge core_clk_i);
        end
    endtask
    task outs(input logic [1:0] e);
        @(negedge core_clk_i);
        cmp({30'h0, sys_rst, irq}, {30'h0, e});
        @(posedge core_clk_i);
    endtask
    task rst(input logic [2:0] c);
        rst_n_i <= 0;
        cfg <= c;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1;
        @(posedge core_clk_i);
    endtask
    initial begin
        void'($urandom(32'h7C5CCF12));
        src = 2'($urandom);
        w = (src == 2'h1 || src == 2'h2);
        rst(3'h5);
        rdc(4'h0, {18'h0, src, 12'h004});
        for (d = 0; d < 4; d++) begin
            bus(1, 4'hC, {31'h0, d[0]});
            bus(1, 4'h0, {22'h0, 2'(d), 8'h07});
            tick(15);
            rdc(4'h8, 32'h0);
            tick(1);
            outs({1'b0, d[0]});
            tick(dly[d] - 1);
            outs({1'b0, d[0]});
            tick(1);
            outs({1'b1, d[0]});
            tick(62);
            outs({1'b1, d[0]});
            tick(1);
            outs({1'b0, d[0]});
            rdc(4'h8, {29'h0, 1'(w), 2'h3});
            cmp(32'(wakes), 32'((d + 1) * w));
            bus(1, 4'h8, 32'h7);
            outs(2'h0);
        end
        k = $urandom_range(14, 1);
        tick(k);
        bus(1, 4'h4, 32'h00005AA5);
        tick(15);
        rdc(4'h8, 32'h0);
        bus(1, 4'h4, 32'h1);
        rdc(4'h4, 32'd15);
        sleep <= 1'b0;
        tick(1);
        tick(2);
        bus(1, 4'h4, 32'h00005AA5);
        tick(k);
        outs(2'h1);
        rdc(4'h4, 32'(k));
        cmp(32'(wakes), 32'(4 * w));
        bus(1, 4'h8, 32'h7);
        bus(1, 4'h4, 32'h00005AA5);
        bus(1, 4'h0, 32'h00000011);
        tick(31);
        rdc(4'h8, 32'h0);
        tick(1);
        outs(2'h1);
        rdc(4'h8, 32'h1);
        rst(3'h0);
        rdc(4'h0, {18'h0, src, 12'h005});
        finish_test;
    end
endmodule
